// File: bench/cdb_host_model.sv
`timescale 1ns/1ps
// Host processor and DMA controller on the strobe port
module cdb_host_model
    import cdb_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [DATA_W-1:0] bus_in,
    output logic                   cs_n_out,
    output logic                   one_out,
    output logic                   zero_out,
    output logic [CH_NUM-1:0]      ack_out,
    output logic                   bs_out,
    output logic                   ss_out,
    output logic [ADDR_W-1:0]      addr_out,
    output logic [DATA_W-1:0]      data_out,
    output logic                   oe_out
);
    // Resting level of the first control pin
    wire logic idle_one = !bs_out || ss_out;

    // Pins rest deselected with strobes high
    initial
    begin
        {cs_n_out, one_out, zero_out} = 3'h7;
        {ack_out, bs_out, ss_out, oe_out} = '0;
        addr_out = '0;
        data_out = '0;
    end

    // Straps move only while the port is idle
    task automatic set_style(input logic bs, input logic ss);
        @(negedge clk_in);
        bs_out = bs;
        ss_out = ss;
        one_out = !bs || ss;
        zero_out = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask : set_style

    // One strobed cycle; select and data held past the strobe
    task automatic access(input logic dma, input logic ch, input logic rd,
                          input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                          output logic [DATA_W-1:0] rdv);
        @(negedge clk_in);
        if (dma)
            ack_out[ch] = 1'b1;
        else
            cs_n_out = 1'b0;
        addr_out = a;
        data_out = wd;
        oe_out = !rd;
        if (bs_out)
            zero_out = rd;
        repeat (3) @(negedge clk_in);
        if (bs_out || rd)
            one_out = !idle_one;
        else
            zero_out = 1'b0;
        repeat (8) @(negedge clk_in);
        rdv = bus_in;
        one_out = idle_one;
        if (!bs_out)
            zero_out = 1'b1;
        repeat (4) @(negedge clk_in);
        cs_n_out = 1'b1;
        ack_out = '0;
        oe_out = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask : access
endmodule : cdb_host_model

// File: bench/cpu_dma_bus_interface_tb.sv
`timescale 1ns/1ps
// Self-checking bench, FIFOs shrunk to four bytes
module cpu_dma_bus_interface_tb;
    import cdb_pkg::*;
    localparam int DEP = 4;
    localparam int BLK = 2;
    logic                          clk_in = 1'b0;
    logic                          nrst_in = 1'b0;
    logic                          cs_n, c1, c0, bs, ss, h_oe, d_oe, r_wr, r_rd;
    logic [CH_NUM-1:0]             dma_ack, tx_v, tx_r, rx_v, rx_r;
    logic [ADDR_W-1:0]             addr, r_addr;
    logic [DATA_W-1:0]             h_d, d_out, r_wd, rv, flt_q;
    logic [CH_NUM-1:0][DATA_W-1:0] tx_d, rx_d;
    logic [DREQ_NUM-1:0]           dreq;
    logic [DATA_W-1:0]             regs [128];
    wire logic [DATA_W-1:0]        bus_w = d_oe ? d_out : (h_oe ? h_d : flt_q);
    int                            fail_count = 0, num_checks = 0, wr_n = 0, rd_n = 0;

    cdb_host_model host (.clk_in(clk_in), .bus_in(bus_w), .cs_n_out(cs_n), .one_out(c1), .zero_out(c0),
        .ack_out(dma_ack), .bs_out(bs), .ss_out(ss), .addr_out(addr), .data_out(h_d), .oe_out(h_oe));
    cdb_host_port #(.DEPTH(DEP), .BLOCK(BLK)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .chip_select_n_in(cs_n), .control_in_one_in(c1), .control_in_zero_in(c0), .dma_acknowledge_in(dma_ack),
        .bus_style_strap_in(bs), .strobe_style_strap_in(ss), .register_address_bus_in(addr),
        .host_data_bus_in(bus_w), .host_data_bus_out(d_out), .host_data_bus_oe_out(d_oe), .reg_wr_out(r_wr),
        .reg_rd_out(r_rd), .reg_addr_out(r_addr), .reg_wdata_out(r_wd), .reg_rdata_in(regs[r_addr]),
        .tx_data_out(tx_d), .tx_valid_out(tx_v), .tx_ready_in(tx_r), .rx_data_in(rx_d), .rx_valid_in(rx_v),
        .rx_ready_out(rx_r), .dma_request_out(dreq));

    // 100 MHz clock
    always #5 clk_in = ~clk_in;

    // Undriven bus flips each cycle; register file behind the port
    always @(posedge clk_in)
    begin
        flt_q <= nrst_in ? ~bus_w : 8'h5A;
        if (r_wr === 1'b1)
        begin
            regs[r_addr] <= r_wd;
            wr_n <= wr_n + 1;
        end
        if (r_rd === 1'b1)
            rd_n <= rd_n + 1;
    end

    // Device must stay off the bus while the host drives it
    always @(negedge clk_in)
        if (h_oe)
            check_val({7'h0, d_oe}, 8'h00, "bus clash");

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check_val

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Register writes and reads in all three strobe styles
    task automatic t_regs();
        int n, m;
        for (int s = 0; s < 3; s++)
        begin
            host.set_style(s != 0, s == 2);
            n = wr_n;
            m = rd_n;
            host.access(1'b0, 1'b0, 1'b0, 7'h7F, 8'hA5 ^ 8'(s), rv);
            host.access(1'b0, 1'b0, 1'b0, 7'h00, 8'h3C + 8'(s), rv);
            check_val(8'(wr_n - n), 8'h02, "write pulses");
            host.access(1'b0, 1'b0, 1'b1, 7'h7F, 8'h00, rv);
            check_val(rv, 8'hA5 ^ 8'(s), "read top register");
            host.access(1'b0, 1'b0, 1'b1, 7'h00, 8'h00, rv);
            check_val(rv, 8'h3C + 8'(s), "read bottom register");
            check_val(8'(rd_n - m), 8'h02, "read pulses");
            check_val({7'h0, d_oe}, 8'h00, "bus released after read");
        end
    endtask : t_regs

    // Fill transmit FIFO past full, then drain with stalls
    task automatic t_dma_tx();
        int n;
        host.set_style(1'b0, 1'b0);
        n = wr_n;
        for (int i = 0; i <= DEP; i++)
            host.access(1'b1, 1'b1, 1'b0, 7'h2A, 8'h10 + 8'(i), rv);
        check_val(8'(wr_n - n), 8'h00, "no register write under dma");
        check_val({6'h0, tx_v}, 8'h02, "only channel one filled");
        for (int i = 0; i < DEP; i++)
        begin
            check_val({7'h0, dreq[1]}, 8'(i >= BLK), "tx request level");
            check_val(tx_d[1], 8'h10 + 8'(i), "tx order");
            tx_r[1] = 1'b1;
            @(negedge clk_in);
            tx_r[1] = 1'b0;
            repeat (2) @(negedge clk_in);
        end
        check_val({6'h0, tx_v}, 8'h00, "fifth byte dropped");
        check_val({4'h0, dreq}, 8'h03, "tx requests back");
    endtask : t_dma_tx

    // Fill receive FIFO until refused, read it out past empty
    task automatic t_dma_rx();
        int n, m;
        host.set_style(1'b1, 1'b0);
        n = 0;
        for (int i = 0; i < 8 && rx_r[0] === 1'b1; i++)
        begin
            rx_d[0] = 8'hC0 + 8'(i);
            rx_v[0] = 1'b1;
            @(negedge clk_in);
            rx_v[0] = 1'b0;
            n++;
            repeat (2) @(negedge clk_in);
        end
        check_val(8'(n), 8'(DEP), "rx depth");
        check_val({4'h0, dreq}, 8'h07, "rx request at block");
        m = rd_n;
        for (int i = 0; i <= DEP; i++)
        begin
            host.access(1'b1, 1'b0, 1'b1, 7'h55, 8'h00, rv);
            check_val(rv, (i < DEP) ? 8'hC0 + 8'(i) : EMPTY_DATA, "rx read");
        end
        check_val({4'h0, dreq}, 8'h03, "rx request off");
        check_val(8'(rd_n - m), 8'h00, "no register read under dma");
    endtask : t_dma_rx

    // Reset, then the scenarios in turn
    initial
    begin
        {tx_r, rx_v, rx_d} = '0;
        repeat (12) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check_val({4'h0, dreq}, 8'h03, "requests after reset");
        check_val({6'h0, rx_r}, 8'h03, "rx ready after reset");
        t_regs();
        t_dma_tx();
        t_dma_rx();
        tally_and_finish();
    end

    // Cuts a hung run short
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        tally_and_finish();
    end
endmodule : cpu_dma_bus_interface_tb

// File: hw/cdb_fifo.sv
`timescale 1ns/1ps
module cdb_fifo
    import cdb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)(
    input  wire logic                       clk_in,
    input  wire logic                       nrst_in,
    input  wire logic                       in_valid_in,
    output logic                            in_ready_out,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output logic                            out_valid_out,
    input  wire logic                       out_ready_in,
    output logic [WIDTH-1:0]                out_data_out,
    output logic [$clog2(DEPTH+1)-1:0]      count_out
);

    localparam int CW = $clog2(DEPTH+1);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW-1:0]    rd_ptr_d;
    logic [CW-1:0]    cnt_d;
    logic             push;
    logic             pop;
    logic             bypass;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    // Handshakes and next occupancy
    assign push     = in_valid_in && in_ready_out;
    assign pop      = out_ready_in && out_valid_out;
    assign rd_ptr_d = pop ? ptr_inc(rd_ptr_q) : rd_ptr_q;
    assign cnt_d    = count_out + CW'(push) - CW'(pop);
    assign bypass   = push && (count_out == CW'(pop));

    // Storage array
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data_in;
    end

    // Pointers, count, flags and registered head word
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            wr_ptr_q      <= '0;
            rd_ptr_q      <= '0;
            count_out     <= '0;
            out_valid_out <= 1'b0;
            in_ready_out  <= 1'b0;
            out_data_out  <= '0;
        end
        else
        begin
            wr_ptr_q      <= push ? ptr_inc(wr_ptr_q) : wr_ptr_q;
            rd_ptr_q      <= rd_ptr_d;
            count_out     <= cnt_d;
            out_valid_out <= (cnt_d != '0);
            in_ready_out  <= (cnt_d != CNT_FULL);
            out_data_out  <= bypass ? in_data_in : mem_q[rd_ptr_d];
        end
    end

endmodule : cdb_fifo

// File: hw/cdb_host_port.sv
`timescale 1ns/1ps
// Functional notes
// - Split-strobe read with select drives the addressed register onto the data bus.
// - Read under DMA acknowledge returns next receive FIFO byte; address ignored.
// - Split-strobe write with select stores data bus value into addressed register.
// - Write under DMA acknowledge pushes data bus value into transmit FIFO.
// - Bus style strap low selects split strobes, high selects enable-style signalling.
// - Enable style: first pin is high enable or low data strobe per strap.
// - Enable style: second pin is read-not-write, choosing read or write access.
// - Eight data lines three-state; driven only during reads, released otherwise.
// - Each channel has 64-byte transmit and receive FIFOs reachable from host.
// - One DMA request output per transmitter and per receiver of each channel.
// - DMA moves data in blocks of 32 bytes between FIFOs and memory.
module cdb_host_port
    import cdb_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int BLOCK = DMA_BLOCK
)(
    input  wire logic                          clk_in,
    input  wire logic                          nrst_in,
    input  wire logic                          chip_select_n_in,
    input  wire logic                          control_in_one_in,
    input  wire logic                          control_in_zero_in,
    input  wire logic [CH_NUM-1:0]             dma_acknowledge_in,
    input  wire logic                          bus_style_strap_in,
    input  wire logic                          strobe_style_strap_in,
    input  wire logic [ADDR_W-1:0]             register_address_bus_in,
    input  wire logic [DATA_W-1:0]             host_data_bus_in,
    output logic [DATA_W-1:0]                  host_data_bus_out,
    output logic                               host_data_bus_oe_out,
    output logic                               reg_wr_out,
    output logic                               reg_rd_out,
    output logic [ADDR_W-1:0]                  reg_addr_out,
    output logic [DATA_W-1:0]                  reg_wdata_out,
    input  wire logic [DATA_W-1:0]             reg_rdata_in,
    output logic [CH_NUM-1:0][DATA_W-1:0]      tx_data_out,
    output logic [CH_NUM-1:0]                  tx_valid_out,
    input  wire logic [CH_NUM-1:0]             tx_ready_in,
    input  wire logic [CH_NUM-1:0][DATA_W-1:0] rx_data_in,
    input  wire logic [CH_NUM-1:0]             rx_valid_in,
    output logic [CH_NUM-1:0]                  rx_ready_out,
    output logic [DREQ_NUM-1:0]                dma_request_out
);

    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] TX_ROOM_MAX = CW'(DEPTH - BLOCK);
    localparam logic [CW-1:0] RX_FILL_MIN = CW'(BLOCK);

    cdb_pins_t                 pins_meta_q;
    cdb_pins_t                 pins_q;
    cdb_acc_t                  acc;
    logic                      act_q;
    logic                      start;
    logic                      strobe_on;
    logic                      enable_act;
    cdb_state_t                state_q;
    cdb_state_t                state_d;
    logic                      fetch_reg_q;
    logic [CH_NUM-1:0]         tx_push;
    logic [CH_NUM-1:0]         rx_pop;
    logic [CH_NUM-1:0][CW-1:0] tx_cnt;
    logic [CH_NUM-1:0][CW-1:0] rx_cnt;
    logic [CH_NUM-1:0][DATA_W-1:0] rx_head;
    logic [CH_NUM-1:0]         rx_has;
    logic [CH_NUM-1:0]         tx_room;

    // Two-stage synchroniser on every host pin
    always_ff @(posedge clk_in)
    begin
        pins_meta_q <= {chip_select_n_in, control_in_one_in, control_in_zero_in, dma_acknowledge_in,
                        bus_style_strap_in, strobe_style_strap_in, register_address_bus_in, host_data_bus_in};
        pins_q      <= pins_meta_q;
    end

    // Strobe decode for both bus styles
    assign enable_act   = pins_q.strobe_style ? !pins_q.ctl_one : pins_q.ctl_one;
    assign strobe_on    = pins_q.bus_style ? enable_act
                                           : (!pins_q.ctl_one || !pins_q.ctl_zero);
    assign acc.read     = pins_q.bus_style ? pins_q.ctl_zero : !pins_q.ctl_one;
    assign acc.sel_reg  = !pins_q.sel_n;
    assign acc.sel_dma  = !acc.sel_reg && (pins_q.dma_ack != '0);
    assign acc.chan     = pins_q.dma_ack[1];
    assign acc.act      = strobe_on && (acc.sel_reg || acc.sel_dma);
    assign start        = acc.act && !act_q && (state_q == ST_IDLE);

    // FIFO side strobes, one cycle each
    assign tx_push = (start && !acc.read && acc.sel_dma) ? CH_NUM'(1) << acc.chan : '0;
    assign rx_pop  = (start &&  acc.read && acc.sel_dma) ? CH_NUM'(1) << acc.chan : '0;

    // Access sequencer next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  if (start) state_d = acc.read ? ST_FETCH : ST_HOLD;
            ST_FETCH: state_d = ST_DRIVE;
            ST_DRIVE: if (!acc.act) state_d = ST_IDLE;
            ST_HOLD:  if (!acc.act) state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    // Sequencer and edge history
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            state_q     <= ST_IDLE;
            act_q       <= 1'b0;
            fetch_reg_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            act_q       <= acc.act;
            fetch_reg_q <= start ? acc.sel_reg : fetch_reg_q;
        end
    end

    // Register access strobes toward the register file
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            reg_wr_out    <= 1'b0;
            reg_rd_out    <= 1'b0;
            reg_addr_out  <= '0;
            reg_wdata_out <= '0;
        end
        else
        begin
            reg_wr_out    <= start && acc.sel_reg && !acc.read;
            reg_rd_out    <= start && acc.sel_reg && acc.read;
            reg_addr_out  <= (start && acc.sel_reg) ? pins_q.addr : reg_addr_out;
            reg_wdata_out <= (start && acc.sel_reg) ? pins_q.data : reg_wdata_out;
        end
    end

    // Read data capture and bus drive
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            host_data_bus_out    <= '0;
            host_data_bus_oe_out <= 1'b0;
        end
        else
        begin
            if (start && acc.read && acc.sel_dma)
                host_data_bus_out <= rx_has[acc.chan] ? rx_head[acc.chan] : EMPTY_DATA;
            else if ((state_q == ST_FETCH) && fetch_reg_q)
                host_data_bus_out <= reg_rdata_in;
            host_data_bus_oe_out <= (state_q == ST_FETCH) || ((state_q == ST_DRIVE) && acc.act);
        end
    end

    // Per-channel transmit and receive FIFOs
    for (genvar c = 0; c < CH_NUM; c++)
    begin : g_ch
        cdb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx (
            .clk_in        (clk_in),
            .nrst_in       (nrst_in),
            .in_valid_in   (tx_push[c]),
            .in_ready_out  (tx_room[c]),
            .in_data_in    (pins_q.data),
            .out_valid_out (tx_valid_out[c]),
            .out_ready_in  (tx_ready_in[c]),
            .out_data_out  (tx_data_out[c]),
            .count_out     (tx_cnt[c])
        );
        cdb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx (
            .clk_in        (clk_in),
            .nrst_in       (nrst_in),
            .in_valid_in   (rx_valid_in[c]),
            .in_ready_out  (rx_ready_out[c]),
            .in_data_in    (rx_data_in[c]),
            .out_valid_out (rx_has[c]),
            .out_ready_in  (rx_pop[c]),
            .out_data_out  (rx_head[c]),
            .count_out     (rx_cnt[c])
        );
    end

    // DMA requests: transmit wants a block of room, receive holds a block
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            dma_request_out <= '0;
        else
            for (int c = 0; c < CH_NUM; c++)
            begin
                dma_request_out[c]          <= (tx_cnt[c] <= TX_ROOM_MAX);
                dma_request_out[CH_NUM + c] <= (rx_cnt[c] >= RX_FILL_MIN);
            end
    end

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    property p_reg_read;
        start && acc.sel_reg && acc.read |=> reg_rd_out ##1 host_data_bus_oe_out
            && host_data_bus_out == $past(reg_rdata_in);
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("register read not driven");

    property p_dma_read;
        start && acc.sel_dma && acc.read && rx_has[acc.chan] |=> ##1 host_data_bus_oe_out
            && host_data_bus_out == $past(rx_head[acc.chan], 2) && !reg_rd_out;
    endproperty
    a_dma_read: assert property (p_dma_read) else $error("FIFO read byte wrong");

    property p_reg_write;
        start && acc.sel_reg && !acc.read |=> reg_wr_out && reg_wdata_out == $past(pins_q.data)
            && reg_addr_out == $past(pins_q.addr);
    endproperty
    a_reg_write: assert property (p_reg_write) else $error("register write lost");

    property p_tx_push;
        tx_push[1] && tx_room[1] && !(tx_ready_in[1] && tx_valid_out[1]) |=> tx_cnt[1] == $past(tx_cnt[1]) + CW'(1);
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("transmit push lost");

    property p_style;
        pins_q.bus_style && !pins_q.strobe_style && pins_q.ctl_one && !pins_q.ctl_zero && acc.sel_reg
            |-> acc.act && !acc.read;
    endproperty
    a_style: assert property (p_style) else $error("enable-style write not decoded");

    property p_oe_read_only;
        host_data_bus_oe_out |-> $past(acc.read) && (state_q == ST_DRIVE || state_q == ST_IDLE);
    endproperty
    a_oe_read_only: assert property (p_oe_read_only) else $error("bus driven outside read");

    property p_release;
        (state_q == ST_DRIVE) && !acc.act |=> !host_data_bus_oe_out;
    endproperty
    a_release: assert property (p_release) else $error("bus not released");

    property p_depth;
        tx_cnt[1] <= CW'(DEPTH) && rx_cnt[0] <= CW'(DEPTH);
    endproperty
    a_depth: assert property (p_depth) else $error("FIFO over depth");

    property p_dreq;
        rx_cnt[0] >= RX_FILL_MIN |=> dma_request_out[CH_NUM];
    endproperty
    a_dreq: assert property (p_dreq) else $error("receive DMA request missing");

endmodule : cdb_host_port

// File: hw/cdb_pkg.sv
package cdb_pkg;

    // Bus widths and channel count
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 7;
    localparam int CH_NUM     = 2;
    localparam int DREQ_NUM   = 2 * CH_NUM;

    // FIFO sizing and DMA block size in bytes
    localparam int FIFO_DEPTH = 64;
    localparam int DMA_BLOCK  = 32;

    // Value driven when a read finds its FIFO empty
    localparam logic [DATA_W-1:0] EMPTY_DATA = 8'h00;

    // Access sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_FETCH = 4'h2,
        ST_DRIVE = 4'h4,
        ST_HOLD  = 4'h8
    } cdb_state_t;

    // Host pins as sampled through the synchroniser
    typedef struct packed {
        logic                    sel_n;
        logic                    ctl_one;
        logic                    ctl_zero;
        logic [CH_NUM-1:0]       dma_ack;
        logic                    bus_style;
        logic                    strobe_style;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
    } cdb_pins_t;

    // Decoded bus access
    typedef struct packed {
        logic                    act;
        logic                    read;
        logic                    sel_reg;
        logic                    sel_dma;
        logic                    chan;
    } cdb_acc_t;

endpackage : cdb_pkg
